// *** hdl/twr_pkg.sv ***
// Constants and types for the two-wire register access block.
// Notes on behaviour
// - As host, drive clock, direction, START, STOP.
// - Standard-mode rate, seven-bit addressing only.
// - No extensions: no high speed, no ten-bit.
// - Host side serves one dedicated configuration EEPROM.
// - Byte after device address is register address.
// - Write each data byte, acknowledge, increment address.
// - Read bytes from current register, then increment.
// - Read opens with START or repeated START.
package twr_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BIT_RATE_HZ = 100_000;
  // Quarter of a bit time; the division is exact at these rates.
  localparam int unsigned QUARTER_CYC = CLK_HZ / (4 * BIT_RATE_HZ);
  localparam logic [6:0] TGT_DEV_ADDR = 7'h2d;
  localparam logic [6:0] EE_DEV_ADDR = 7'h50;
  localparam logic [7:0] EE_BASE_ADDR = 8'h00;
  localparam logic [7:0] LOAD_LEN = 8'h10;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  typedef enum logic [2:0] {
    LD_IDLE, LD_START, LD_DEVW, LD_WADDR, LD_RSTART, LD_DEVR, LD_READ, LD_STOP
  } twr_ld_st_t;

  typedef enum logic [2:0] {
    TG_IDLE, TG_DEV, TG_REG, TG_WDATA, TG_RDATA
  } twr_tg_st_t;
endpackage

// *** hdl/twr_top.sv ***
// EEPROM loader as bus host and register target on a second two-wire link.
`timescale 1ns/10ps
module twr_top
  import twr_pkg::*;
(
  // System clock domain
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Loader control
  input wire logic load_start_i,
  output logic load_busy_o,
  output logic load_done_o,
  output logic load_err_o,
  output logic cfg_valid_o,
  output logic [7:0] cfg_addr_o,
  output logic [7:0] cfg_data_o,
  // EEPROM bus, open drain
  output logic ee_scl_o,
  output logic ee_scl_oe_o,
  input wire logic ee_sda_i,
  output logic ee_sda_o,
  output logic ee_sda_oe_o,
  // Target link domain
  input wire logic link_clk_i,
  input wire logic tgt_scl_i,
  input wire logic tgt_sda_i,
  output logic tgt_sda_o,
  output logic tgt_sda_oe_o,
  // Register writes seen on the target link
  output logic reg_wr_o,
  output logic [7:0] reg_wr_addr_o,
  output logic [7:0] reg_wr_data_o
);

  // ---------------- Loader, system domain ----------------
  twr_ld_st_t ld_st;
  logic [5:0] qcnt;
  logic [1:0] quarter;
  logic [3:0] ld_bcnt;
  logic [7:0] ld_tx;
  logic [7:0] ld_rx;
  logic [7:0] ld_nbyte;
  logic ld_nack;
  logic ee_sda_m;
  logic ee_sda_s;
  logic tick;
  logic op_end;
  logic next_scl_low;
  logic next_sda_low;
  logic ld_bit;
  logic ld_is_byte;

  assign tick = (ld_st != LD_IDLE) && (qcnt == 6'(QUARTER_CYC - 1));
  assign op_end = tick && (quarter == 2'h3);
  assign ld_is_byte = (ld_st == LD_DEVW) || (ld_st == LD_WADDR) ||
                      (ld_st == LD_DEVR) || (ld_st == LD_READ);

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ee_sda_m <= 1'b1;
      ee_sda_s <= 1'b1;
    end else if (ce_i) begin
      ee_sda_m <= ee_sda_i;
      ee_sda_s <= ee_sda_m;
    end
  end

  // Bit value put on the data line; reads release it except for the acknowledge of every byte but the last.
  always_comb begin
    ld_bit = 1'b1;
    if (ld_st == LD_READ) begin
      if (ld_bcnt == ACK_BIT) begin
        ld_bit = (ld_nbyte == LOAD_LEN - 8'h01);
      end
    end else if (ld_bcnt != ACK_BIT) begin
      ld_bit = ld_tx[7];
    end
  end

  // Every operation spans four quarters with the clock high in the middle two, except STOP, which keeps it high for the last three.
  always_comb begin
    next_scl_low = 1'b0;
    next_sda_low = 1'b0;
    unique case (ld_st)
      LD_IDLE: begin
        next_scl_low = 1'b0;
      end
      LD_START, LD_RSTART: begin
        next_scl_low = (quarter == 2'h0) || (quarter == 2'h3);
        next_sda_low = quarter[1];
      end
      LD_STOP: begin
        next_scl_low = (quarter == 2'h0);
        next_sda_low = !quarter[1];
      end
      LD_DEVW, LD_WADDR, LD_DEVR, LD_READ: begin
        next_scl_low = (quarter == 2'h0) || (quarter == 2'h3);
        next_sda_low = !ld_bit;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ee_scl_o <= 1'b0;
      ee_sda_o <= 1'b0;
      ee_scl_oe_o <= 1'b0;
      ee_sda_oe_o <= 1'b0;
    end else if (ce_i) begin
      ee_scl_oe_o <= next_scl_low;
      ee_sda_oe_o <= next_sda_low;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      qcnt <= 6'h00;
      quarter <= 2'h0;
    end else if (ce_i) begin
      if (ld_st == LD_IDLE || tick) begin
        qcnt <= 6'h00;
      end else begin
        qcnt <= qcnt + 6'h01;
      end
      if (ld_st == LD_IDLE) begin
        quarter <= 2'h0;
      end else if (tick) begin
        quarter <= quarter + 2'h1;
      end
    end
  end

  // Only one EEPROM is ever addressed, with a fixed seven-bit address.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ld_st <= LD_IDLE;
      ld_bcnt <= 4'h0;
      ld_tx <= 8'h00;
      ld_rx <= 8'h00;
      ld_nbyte <= 8'h00;
      ld_nack <= 1'b0;
      load_busy_o <= 1'b0;
      load_done_o <= 1'b0;
      load_err_o <= 1'b0;
      cfg_valid_o <= 1'b0;
      cfg_addr_o <= 8'h00;
      cfg_data_o <= 8'h00;
    end else if (ce_i) begin
      load_done_o <= 1'b0;
      cfg_valid_o <= 1'b0;
      if (ld_st == LD_IDLE) begin
        if (load_start_i) begin
          ld_st <= LD_START;
          ld_nbyte <= 8'h00;
          load_busy_o <= 1'b1;
          load_err_o <= 1'b0;
        end
      end
      if (tick && quarter == 2'h2 && ld_is_byte) begin
        if (ld_bcnt == ACK_BIT) begin
          ld_nack <= ee_sda_s;
        end else begin
          ld_rx <= {ld_rx[6:0], ee_sda_s};
        end
      end
      if (op_end) begin
        if (ld_is_byte && ld_bcnt != ACK_BIT) begin
          ld_bcnt <= ld_bcnt + 4'h1;
          ld_tx <= {ld_tx[6:0], 1'b1};
        end else begin
          ld_bcnt <= 4'h0;
          unique case (ld_st)
            LD_IDLE: ld_st <= LD_IDLE;
            LD_START: begin
              ld_st <= LD_DEVW;
              ld_tx <= {EE_DEV_ADDR, 1'b0};
            end
            LD_DEVW: begin
              ld_st <= ld_nack ? LD_STOP : LD_WADDR;
              load_err_o <= ld_nack;
              ld_tx <= EE_BASE_ADDR;
            end
            LD_WADDR: begin
              ld_st <= ld_nack ? LD_STOP : LD_RSTART;
              load_err_o <= ld_nack;
            end
            LD_RSTART: begin
              ld_st <= LD_DEVR;
              ld_tx <= {EE_DEV_ADDR, 1'b1};
            end
            LD_DEVR: begin
              ld_st <= ld_nack ? LD_STOP : LD_READ;
              load_err_o <= ld_nack;
            end
            LD_READ: begin
              cfg_valid_o <= 1'b1;
              cfg_addr_o <= EE_BASE_ADDR + ld_nbyte;
              cfg_data_o <= ld_rx;
              ld_nbyte <= ld_nbyte + 8'h01;
              if (ld_nbyte == LOAD_LEN - 8'h01) begin
                ld_st <= LD_STOP;
              end
            end
            LD_STOP: begin
              ld_st <= LD_IDLE;
              load_busy_o <= 1'b0;
              load_done_o <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  // ---------------- Target, link domain ----------------
  logic rst_l_m;
  logic rst_l;
  logic ce_l_m;
  logic ce_l;
  logic scl_m;
  logic scl_s;
  logic scl_d;
  logic sda_m;
  logic sda_s;
  logic sda_d;
  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;
  twr_tg_st_t tg_st;
  logic [3:0] tg_cnt;
  logic [7:0] tg_sh;
  logic [7:0] tg_ptr;
  logic tg_rw;
  logic tg_hnack;
  logic tg_lead;
  logic [7:0] regs [0:255];
  logic [7:0] wr_addr_l;
  logic [7:0] wr_data_l;
  logic wr_tgl;

  always_ff @(posedge link_clk_i) begin
    rst_l_m <= reset_i;
    rst_l <= rst_l_m;
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      ce_l_m <= 1'b0;
      ce_l <= 1'b0;
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      ce_l_m <= ce_i;
      ce_l <= ce_l_m;
      if (ce_l) begin
        scl_m <= tgt_scl_i;
        scl_s <= scl_m;
        scl_d <= scl_s;
        sda_m <= tgt_sda_i;
        sda_s <= sda_m;
        sda_d <= sda_s;
      end
    end
  end

  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;

  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      tg_st <= TG_IDLE;
      tg_cnt <= 4'h0;
      tg_sh <= 8'h00;
      tg_ptr <= 8'h00;
      tg_rw <= 1'b0;
      tg_hnack <= 1'b0;
      tg_lead <= 1'b0;
      tgt_sda_o <= 1'b0;
      tgt_sda_oe_o <= 1'b0;
      wr_addr_l <= 8'h00;
      wr_data_l <= 8'h00;
      wr_tgl <= 1'b0;
      for (int i = 0; i < 256; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (ce_l) begin
      if (bus_start) begin
        // A repeated START keeps the register pointer for the read.
        tg_st <= TG_DEV;
        tg_cnt <= 4'h0;
        // The clock fall that closes the START is not a bit boundary.
        tg_lead <= 1'b1;
        tgt_sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
        tg_st <= TG_IDLE;
        tgt_sda_oe_o <= 1'b0;
      end else if (tg_st != TG_IDLE) begin
        if (scl_rise) begin
          if (tg_cnt == ACK_BIT) begin
            tg_hnack <= sda_s;
          end else if (tg_st != TG_RDATA) begin
            tg_sh <= {tg_sh[6:0], sda_s};
          end
        end else if (scl_fall && tg_lead) begin
          tg_lead <= 1'b0;
        end else if (scl_fall) begin
          if (tg_cnt < 4'(LAST_DATA_BIT)) begin
            tg_cnt <= tg_cnt + 4'h1;
            if (tg_st == TG_RDATA) begin
              tgt_sda_oe_o <= !tg_sh[7];
              tg_sh <= {tg_sh[6:0], 1'b1};
            end
          end else if (tg_cnt == 4'(LAST_DATA_BIT)) begin
            tg_cnt <= ACK_BIT;
            unique case (tg_st)
              TG_DEV: begin
                // Seven-bit address compare only; other patterns are ignored.
                if (tg_sh[7:1] == TGT_DEV_ADDR) begin
                  tgt_sda_oe_o <= 1'b1;
                  tg_rw <= tg_sh[0];
                end else begin
                  tg_st <= TG_IDLE;
                  tgt_sda_oe_o <= 1'b0;
                end
              end
              TG_REG: begin
                tg_ptr <= tg_sh;
                tgt_sda_oe_o <= 1'b1;
              end
              TG_WDATA: begin
                regs[tg_ptr] <= tg_sh;
                wr_addr_l <= tg_ptr;
                wr_data_l <= tg_sh;
                wr_tgl <= !wr_tgl;
                tg_ptr <= tg_ptr + 8'h01;
                tgt_sda_oe_o <= 1'b1;
              end
              TG_RDATA: begin
                tg_ptr <= tg_ptr + 8'h01;
                tgt_sda_oe_o <= 1'b0;
              end
              default: tg_st <= TG_IDLE;
            endcase
          end else begin
            tg_cnt <= 4'h0;
            tgt_sda_oe_o <= 1'b0;
            unique case (tg_st)
              TG_DEV: begin
                if (tg_rw) begin
                  tg_st <= TG_RDATA;
                  tg_sh <= {regs[tg_ptr][6:0], 1'b1};
                  tgt_sda_oe_o <= !regs[tg_ptr][7];
                end else begin
                  tg_st <= TG_REG;
                end
              end
              TG_REG: tg_st <= TG_WDATA;
              TG_WDATA: tg_st <= TG_WDATA;
              TG_RDATA: begin
                if (tg_hnack) begin
                  tg_st <= TG_IDLE;
                end else begin
                  tg_sh <= {regs[tg_ptr][6:0], 1'b1};
                  tgt_sda_oe_o <= !regs[tg_ptr][7];
                end
              end
              default: tg_st <= TG_IDLE;
            endcase
          end
        end
      end
    end
  end

  // ---------------- Write events into the system domain ----------------
  // Address and data are held for nine link bit times, far longer than the toggle sync.
  logic wr_tgl_m;
  logic wr_tgl_s;
  logic wr_tgl_d;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_tgl_m <= 1'b0;
      wr_tgl_s <= 1'b0;
      wr_tgl_d <= 1'b0;
      reg_wr_o <= 1'b0;
      reg_wr_addr_o <= 8'h00;
      reg_wr_data_o <= 8'h00;
    end else if (ce_i) begin
      wr_tgl_m <= wr_tgl;
      wr_tgl_s <= wr_tgl_m;
      wr_tgl_d <= wr_tgl_s;
      reg_wr_o <= wr_tgl_s ^ wr_tgl_d;
      if (wr_tgl_s ^ wr_tgl_d) begin
        reg_wr_addr_o <= wr_addr_l;
        reg_wr_data_o <= wr_data_l;
      end
    end
  end

endmodule // twr_top

// *** bench/twr_properties.sv ***
// Checker for the two-wire register access block.
`timescale 1ns/10ps
module twr_properties
  import twr_pkg::*;
(
  // System domain
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic load_start_i,
  input wire logic load_busy_o,
  input wire logic load_done_o,
  input wire logic load_err_o,
  input wire logic cfg_valid_o,
  input wire logic [7:0] cfg_addr_o,
  input wire logic ee_scl_oe_o,
  input wire logic ee_sda_oe_o,
  input wire logic reg_wr_o,
  // Link domain
  input wire logic link_clk_i,
  input wire logic tgt_scl_i,
  input wire logic tgt_sda_oe_o
);
  logic [7:0] last_addr;
  always_ff @(posedge clk_sys_i) begin
    if (cfg_valid_o) begin
      last_addr <= cfg_addr_o;
    end
  end
  a_start_busy: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    load_start_i && ce_i && !load_busy_o |=> load_busy_o) else $error("busy late");
  a_done_pulse: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    load_done_o |=> !load_done_o) else $error("done too long");
  a_idle_released: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !load_busy_o && !$past(load_busy_o) |-> !ee_scl_oe_o && !ee_sda_oe_o)
    else $error("bus driven while idle");
  a_scl_high_time: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(ee_scl_oe_o) |-> ##99 !ee_scl_oe_o) else $error("clock high too short");
  a_scl_low_time: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(ee_scl_oe_o) |-> ##49 ee_scl_oe_o) else $error("clock low too short");
  a_start_shape: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(ee_sda_oe_o) && !ee_scl_oe_o |-> ##50 (ee_scl_oe_o && ee_sda_oe_o))
    else $error("bad start condition");
  a_cfg_in_load: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cfg_valid_o |-> load_busy_o && !load_err_o) else $error("stray config byte");
  a_cfg_addr_step: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cfg_valid_o && cfg_addr_o != EE_BASE_ADDR |-> cfg_addr_o == last_addr + 8'h01)
    else $error("config address skipped");
  a_wr_pulse: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_o |=> !reg_wr_o) else $error("write pulse too long");
  a_tgt_sda_low: assert property (@(posedge link_clk_i) disable iff (reset_i)
    $changed(tgt_sda_oe_o) |-> !tgt_scl_i) else $error("data moved with clock high");
  c_load_ok: cover property (@(posedge clk_sys_i) load_done_o && !load_err_o);
  c_load_err: cover property (@(posedge clk_sys_i) load_done_o && load_err_o);
  c_reg_wr: cover property (@(posedge clk_sys_i) reg_wr_o);
endmodule // twr_properties

bind twr_top twr_properties i_twr_properties (.clk_sys_i, .reset_i, .ce_i, .load_start_i,
  .load_busy_o, .load_done_o, .load_err_o, .cfg_valid_o, .cfg_addr_o, .ee_scl_oe_o,
  .ee_sda_oe_o, .reg_wr_o, .link_clk_i, .tgt_scl_i, .tgt_sda_oe_o);

// *** bench/twr_ee_model.sv ***
// Behavioural configuration memory on the loader's two-wire bus.
`timescale 1ns/10ps
module twr_ee_model
  import twr_pkg::*;
#(
  parameter logic [7:0] DATA_XOR = 8'hc3
)
(
  // Bus levels and commanded refusal
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic nack_i,
  // Pull-down on data
  output logic sda_oe_o
);
  logic [3:0] cnt = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] ptr = 8'h00;
  logic [1:0] ph = 2'h0;
  logic go = 1'b0;
  logic ak;
  initial sda_oe_o = 1'b0;
  always @(negedge sda_i) begin
    if (scl_i) begin
      go = 1'b1;
      // The clock fall that closes a START wraps the count to zero.
      cnt = 4'hf;
      ph = 2'h0;
    end
  end
  // Data only moves with the clock low, so a rise with it high is a stop.
  always @(posedge sda_i) begin
    if (scl_i) begin
      go = 1'b0;
    end
  end
  always @(posedge scl_i) begin
    if (go && cnt < 4'h8 && ph != 2'h3) begin
      sh = {sh[6:0], sda_i};
    end
    if (go && cnt == 4'h8 && ph == 2'h3 && sda_i) begin
      go = 1'b0;
    end
  end
  always @(negedge scl_i) begin
    ak = 1'b0;
    if (go && cnt == 4'h8) begin
      cnt = 4'h0;
      if (ph == 2'h3) begin
        sh = ptr ^ DATA_XOR;
        ptr = ptr + 8'h01;
      end
    end else if (go) begin
      cnt = cnt + 4'h1;
      if (cnt == 4'h8 && ph != 2'h3) begin
        ak = ph != 2'h0 || (sh[7:1] == EE_DEV_ADDR && !nack_i);
        go = ak;
        ptr = ph == 2'h1 ? sh : ptr;
        ph = ph == 2'h0 ? {sh[0], 1'b1} : 2'h2;
      end
    end
    sda_oe_o = go && (ak || (ph == 2'h3 && cnt < 4'h8 && !sh[3'h7 - cnt[2:0]]));
  end
endmodule // twr_ee_model

// *** bench/tb_twr_top.sv ***
// Self-checking bench for the two-wire register access block.
`timescale 1ns/10ps
module tb_twr_top;
  import twr_pkg::*;
  localparam logic [7:0] XOR = 8'h3c;
  logic clk_sys_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic load_start_i = 1'b0;
  logic nack = 1'b0;
  logic ce = 1'b1;
  logic scl = 1'b1;
  logic sda = 1'b1;
  logic load_busy_o, load_done_o, load_err_o, cfg_valid_o, ee_scl_oe_o, ee_sda_oe_o;
  logic ee_oe, tgt_sda_oe_o, reg_wr_o;
  logic [7:0] cfg_addr_o, cfg_data_o, reg_wr_addr_o, reg_wr_data_o;
  logic [7:0] mem [256] = '{default: 8'h00};
  logic [15:0] cq [$];
  logic [15:0] wq [$];
  int failures = 0;
  int cmp_count = 0;
  wire logic ee_sda_i = !(ee_sda_oe_o || ee_oe);
  wire logic tgt_sda_i = sda && !tgt_sda_oe_o;
  twr_top i_twr_top (
    .clk_sys_i, .reset_i, .ce_i(ce), .load_start_i, .load_busy_o, .load_done_o,
    .load_err_o, .cfg_valid_o, .cfg_addr_o, .cfg_data_o, .ee_scl_o(), .ee_scl_oe_o,
    .ee_sda_i, .ee_sda_o(), .ee_sda_oe_o, .link_clk_i, .tgt_scl_i(scl), .tgt_sda_i,
    .tgt_sda_o(), .tgt_sda_oe_o, .reg_wr_o, .reg_wr_addr_o, .reg_wr_data_o
  );
  twr_ee_model #(.DATA_XOR(XOR)) i_twr_ee_model (
    .scl_i(!ee_scl_oe_o), .sda_i(ee_sda_i), .nack_i(nack), .sda_oe_o(ee_oe)
  );
  initial forever #25 clk_sys_i = !clk_sys_i;
  initial begin
    #7;
    forever #62.5 link_clk_i = !link_clk_i;
  end
  task automatic complete_run();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // A quarter bit of 500 ns keeps the clock low for eight link samples.
  task automatic q4();
    repeat (10) @(negedge clk_sys_i);
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda = b;
    q4();
    scl = 1'b1;
    q4();
    s = tgt_sda_i;
    q4();
    scl = 1'b0;
    q4();
  endtask
  task automatic t_start();
    sda = 1'b1;
    q4();
    scl = 1'b1;
    q4();
    sda = 1'b0;
    q4();
    scl = 1'b0;
    q4();
  endtask
  task automatic t_stop();
    sda = 1'b0;
    q4();
    scl = 1'b1;
    q4();
    sda = 1'b1;
    q4();
  endtask
  task automatic t_byte(input logic [7:0] b, input logic ak);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    chk("acknowledge", {15'h0000, !ak}, {15'h0000, s});
  endtask
  task automatic t_read(input logic [7:0] e, input logic last);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
    chk("read data", {8'h00, e}, {8'h00, d});
  endtask
  task automatic t_addr(input logic [7:0] a);
    t_start();
    t_byte({TGT_DEV_ADDR, 1'b0}, 1'b1);
    t_byte(a, 1'b1);
  endtask
  task automatic t_write(input logic [7:0] a, input int n);
    logic [7:0] d;
    t_addr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      mem[a] = d;
      wq.push_back({a, d});
      t_byte(d, 1'b1);
      a++;
    end
    t_stop();
  endtask
  task automatic t_rd(input logic [7:0] a, input int n, input logic sr);
    t_addr(a);
    if (!sr) t_stop();
    t_start();
    t_byte({TGT_DEV_ADDR, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) t_read(mem[8'(a + i)], i == n - 1);
    t_stop();
  endtask
  task automatic run_load(input logic err);
    load_start_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    load_start_i = 1'b0;
    chk("busy", 16'h0001, {15'h0000, load_busy_o});
    for (int i = 0; i < 40000 && load_done_o !== 1'b1; i++) @(negedge clk_sys_i);
    chk("load done", 16'h0001, {15'h0000, load_done_o});
    chk("load error", {15'h0000, err}, {15'h0000, load_err_o});
    @(negedge clk_sys_i);
  endtask
  // Outputs are looked at mid-cycle, well away from the edge that launches them.
  always @(negedge clk_sys_i) begin
    if (reg_wr_o === 1'b1) begin
      chk("register write", wq.size() > 0 ? wq.pop_front() : 16'hxxxx,
        {reg_wr_addr_o, reg_wr_data_o});
    end
    if (cfg_valid_o === 1'b1) begin
      chk("config byte", cq.size() > 0 ? cq.pop_front() : 16'hxxxx,
        {cfg_addr_o, cfg_data_o});
    end
  end
  initial begin
    #(90000 * 50);
    failures++;
    complete_run();
  end
  initial begin
    void'($urandom(78779));
    repeat (10) @(negedge clk_sys_i);
    reset_i = 1'b0;
    fork
      begin
        for (int i = 0; i < int'(LOAD_LEN); i++) begin
          cq.push_back({EE_BASE_ADDR + 8'(i), (EE_BASE_ADDR + 8'(i)) ^ XOR});
        end
        run_load(1'b0);
        nack = 1'b1;
        run_load(1'b1);
      end
      begin
        t_rd(8'h40, 1, 1'b1);
        t_write(8'hfe, 3);
        t_rd(8'hfe, 3, 1'b0);
        t_rd(8'hff, 2, 1'b1);
        t_start();
        t_byte({7'h11, 1'b0}, 1'b0);
        t_stop();
        repeat (4) t_write(8'($urandom), 2);
        t_rd(8'hfe, 4, 1'b1);
      end
    join
    repeat (20) @(negedge clk_sys_i);
    // A start request while the enable is low must not be taken.
    ce = 1'b0;
    load_start_i = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    chk("frozen busy", 16'h0000, {15'h0000, load_busy_o});
    load_start_i = 1'b0;
    ce = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    chk("queues", 16'h0000, 16'(cq.size() + wq.size()));
    complete_run();
  end
endmodule // tb_twr_top
